//--- inc/asr_pkg.sv
// Purpose: Shared constants for the serial result readout link
// Assumes: 40 MHz mclk on both ends
// Notes:   Long timer counts are overridable at the device top
package asr_pkg;
	localparam int MCLK_HZ      = 40_000_000;
	localparam int CYC_PER_US   = MCLK_HZ / 1_000_000;
	localparam int WORD_W       = 32;
	localparam int RES_W        = 20;
	localparam int PAD_W        = 4;
	localparam int CNT_W        = 6;
	localparam int IDX_W        = 5;
	localparam int TMR_W        = 32;
	// Oscillator start and filter timing, in microseconds
	localparam int OSC_START_US = 1_000;
	localparam int PERIOD_10_US = 100_000;
	localparam int PERIOD_16_US = 60_000;
	localparam int SETTLE_10_US = 300_000;
	localparam int SETTLE_16_US = 120_000;
	localparam int OSC_CYC      = OSC_START_US * CYC_PER_US;
	localparam int PERIOD_10_CYC = PERIOD_10_US * CYC_PER_US;
	localparam int PERIOD_16_CYC = PERIOD_16_US * CYC_PER_US;
	localparam int SETTLE_10_CYC = SETTLE_10_US * CYC_PER_US;
	localparam int SETTLE_16_CYC = SETTLE_16_US * CYC_PER_US;
	// Host serial clock half period and its floor, in mclk cycles
	localparam int HOST_HALF    = 10;
	localparam int HOST_HALF_MIN = 8;
	localparam logic [PAD_W-1:0] PAD_ZERO  = 4'h0;
	localparam logic [1:0]       CHECK_PAT = 2'h1;
	localparam logic             RDY_FRESH = 1'h0;
	localparam logic [1:0]       PART_CODE_DFLT = 2'h2;

	function automatic logic [CNT_W-1:0] bin2gray(
		input logic [CNT_W-1:0] b
	);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [CNT_W-1:0] gray2bin(
		input logic [CNT_W-1:0] g
	);
		logic [CNT_W-1:0] b;
		b = g;
		for (int i = CNT_W - 2; i >= 0; i--)
		begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction
endpackage

//--- inc/asr_if.sv
// Purpose: Two-wire link between converter port and host reader
// Assumes: Line is pulled high whenever the device does not drive it
// Notes:   Resolves the shared ready/data line from its enable
`timescale 1ns/1ps
`default_nettype none
interface asr_if;
	logic sclk;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	// Pull-up resolution of the ready/data line
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	modport dev
	(
		input  sclk,
		output sdo,
		output sdo_oe
	);
	modport host
	(
		output sclk,
		input  sdo_line
	);
endinterface
`default_nettype wire

//--- src/asr_dev.sv
// Purpose: Converter-side readout port: ready, shift-out and timing
// Assumes: Host supplies sclk idle high; bits change on sclk fall
// Notes:   Counters face sclk; pin logic and timers run on mclk
// Notes on behaviour
// RULE1 - Link is serial clock plus shared line
// RULE2 - Line goes low when new word waits
// RULE3 - Each read shifts 32 bits, one per clock
// RULE4 - Result field is 20 bits plus four zeros
// RULE5 - Status byte order: ready, rate, error, part, gain, check
// RULE6 - Line returns high after complete read
// RULE7 - Unread word: line rises before update
// RULE8 - Each result is readable only once
// RULE9 - Every conversion is written to the register
// RULE10 - Completion restarts serial state, drops partial read
// RULE11 - Host finishes read before next completion
// RULE12 - Powerdown low tristates the line
// RULE13 - Oscillator start wait, then continuous conversion
// RULE14 - Line high after powerdown release until result
// RULE15 - Rate or gain change restarts settling, line high
// RULE16 - Host avoids reads across rate or gain change
// RULE17 - Ready status bit is zero for fresh word
// RULE18 - Rate bit one for 10 Hz, gain bit one for unity
// RULE19 - Error bit set on out-of-range input
// RULE20 - Fixed part code in every word
// RULE21 - Check pattern is 0 then 1
// RULE22 - Result is offset binary
// RULE23 - Word goes out most significant bit first
`timescale 1ns/1ps
`default_nettype none
module asr_dev
	import asr_pkg::*;
#(
	parameter int         OSC_CYCLES  = OSC_CYC,
	parameter int         PER10_CYCLES = PERIOD_10_CYC,
	parameter int         PER16_CYCLES = PERIOD_16_CYC,
	parameter int         SET10_CYCLES = SETTLE_10_CYC,
	parameter int         SET16_CYCLES = SETTLE_16_CYC,
	// Arbitrary part code value
	parameter logic [1:0] PART_CODE   = PART_CODE_DFLT
)
(
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	input  wire logic             powerdown_reset_n,
	input  wire logic             rate_sel,
	input  wire logic             gain_sel,
	input  wire logic [RES_W-1:0] conv_result,
	input  wire logic             conv_overrange,
	asr_if.dev                    lnk
);
	typedef enum logic [1:0] {ST_OFF, ST_OSC, ST_SETTLE, ST_RUN} asr_st_t;

	asr_st_t           state_r;
	logic [TMR_W-1:0]  timer_r, settle_cyc, period_cyc;
	logic [1:0]        pd_s_r, rate_s_r, gain_s_r, ovr_s_r;
	logic [RES_W-1:0]  res_s1_r, res_s2_r;
	logic [CNT_W-1:0]  fall_b_r, fall_g_r, rise_b_r, rise_g_r;
	logic [CNT_W-1:0]  fall_s1_r, fall_s2_r, rise_s1_r, rise_s2_r;
	logic [CNT_W-1:0]  base_f_r, base_r_r, fall_now, rise_now;
	logic [CNT_W-1:0]  pos_f, pos_r, idx;
	logic [WORD_W-1:0] word_r;
	logic              rate_q_r, gain_q_r, link_clr_r, fresh_r;
	logic              sdo_r, sdo_oe_r, pd_on, cfg_chg;
	logic              converting, conv_done, pre_upd, rd_done;

	initial
	begin
		if (OSC_CYCLES < 2 || PER10_CYCLES < 2 || PER16_CYCLES < 2 ||
			SET10_CYCLES < 2 || SET16_CYCLES < 2)
			$error("asr_dev: timer counts must be at least 2");
	end

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge mclk)
	begin
		pd_s_r   <= {pd_s_r[0], powerdown_reset_n};
		rate_s_r <= {rate_s_r[0], rate_sel};
		gain_s_r <= {gain_s_r[0], gain_sel};
		ovr_s_r  <= {ovr_s_r[0], conv_overrange};
		res_s1_r <= conv_result;
		res_s2_r <= res_s1_r;
		rate_q_r <= rate_s_r[1];
		gain_q_r <= gain_s_r[1];
	end

	assign pd_on      = pd_s_r[1];
	// RULE15 pin change detect
	assign cfg_chg    = (rate_s_r[1] != rate_q_r) ||
		(gain_s_r[1] != gain_q_r);
	assign settle_cyc = rate_s_r[1] ? TMR_W'(SET10_CYCLES) :
		TMR_W'(SET16_CYCLES);
	assign period_cyc = rate_s_r[1] ? TMR_W'(PER10_CYCLES) :
		TMR_W'(PER16_CYCLES);
	assign converting = (state_r == ST_SETTLE) || (state_r == ST_RUN);
	// RULE9 every completion loads
	assign conv_done  = converting && (timer_r == '0) && !cfg_chg;
	// RULE7 early rise before update
	assign pre_upd    = converting && (timer_r == TMR_W'(1));

	////////////////////////////////////////////////////////////////////
	// Conversion timing
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !pd_on)
		begin
			state_r <= ST_OFF;
			timer_r <= '0;
		end
		else
		begin
			case (state_r)
				ST_OFF:
				begin
					// RULE13 oscillator start wait
					state_r <= ST_OSC;
					timer_r <= TMR_W'(OSC_CYCLES - 1);
				end
				ST_OSC:
				begin
					if (timer_r == '0)
					begin
						state_r <= ST_SETTLE;
						timer_r <= settle_cyc - TMR_W'(1);
					end
					else
						timer_r <= timer_r - TMR_W'(1);
				end
				ST_SETTLE, ST_RUN:
				begin
					// RULE15 restart full settling
					if (cfg_chg)
					begin
						state_r <= ST_SETTLE;
						timer_r <= settle_cyc - TMR_W'(1);
					end
					// RULE13 continuous conversion
					else if (timer_r == '0)
					begin
						state_r <= ST_RUN;
						timer_r <= period_cyc - TMR_W'(1);
					end
					else
						timer_r <= timer_r - TMR_W'(1);
				end
				default:
				begin
					state_r <= ST_OFF;
					timer_r <= '0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Serial clock edge counters, link domain
	always_ff @(posedge mclk)
	begin
		link_clr_r <= sys_rst || !pd_on;
	end

	// RULE3 count falling edges
	always_ff @(negedge lnk.sclk or posedge link_clr_r)
	begin
		if (link_clr_r)
		begin
			fall_b_r <= '0;
			fall_g_r <= '0;
		end
		else
		begin
			fall_b_r <= fall_b_r + 1'b1;
			fall_g_r <= bin2gray(fall_b_r + 1'b1);
		end
	end

	always_ff @(posedge lnk.sclk or posedge link_clr_r)
	begin
		if (link_clr_r)
		begin
			rise_b_r <= '0;
			rise_g_r <= '0;
		end
		else
		begin
			rise_b_r <= rise_b_r + 1'b1;
			rise_g_r <= bin2gray(rise_b_r + 1'b1);
		end
	end

	always_ff @(posedge mclk)
	begin
		fall_s1_r <= fall_g_r;
		fall_s2_r <= fall_s1_r;
		rise_s1_r <= rise_g_r;
		rise_s2_r <= rise_s1_r;
	end

	assign fall_now = gray2bin(fall_s2_r);
	assign rise_now = gray2bin(rise_s2_r);
	assign pos_f    = fall_now - base_f_r;
	assign pos_r    = rise_now - base_r_r;
	assign idx      = CNT_W'(WORD_W) - pos_f;
	// RULE6 full word seen
	assign rd_done  = fresh_r && (pos_r >= CNT_W'(WORD_W));

	////////////////////////////////////////////////////////////////////
	// Result register and read-once state
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			word_r <= '0;
		// RULE4 RULE5 RULE17 RULE18 RULE19 RULE20 RULE21 RULE22 word
		else if (conv_done)
			word_r <= {res_s2_r, PAD_ZERO, RDY_FRESH, rate_s_r[1],
				ovr_s_r[1], PART_CODE, gain_s_r[1], CHECK_PAT};
	end

	// RULE10 restart serial position
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !pd_on)
		begin
			base_f_r <= '0;
			base_r_r <= '0;
		end
		else if (conv_done)
		begin
			base_f_r <= fall_now;
			base_r_r <= rise_now;
		end
	end

	always_ff @(posedge mclk)
	begin
		// RULE12 RULE14 RULE15 line held high
		if (sys_rst || !pd_on || cfg_chg || pre_upd)
			fresh_r <= 1'b0;
		// RULE2 new word waiting
		else if (conv_done)
			fresh_r <= 1'b1;
		// RULE8 read only once
		else if (rd_done)
			fresh_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Line driver
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sdo_r    <= 1'b1;
			sdo_oe_r <= 1'b0;
		end
		else
		begin
			// RULE12 tristate in powerdown
			sdo_oe_r <= pd_on && (state_r != ST_OFF);
			if (!fresh_r || pos_f > CNT_W'(WORD_W))
				sdo_r <= 1'b1;
			// RULE2 ready low
			else if (pos_f == '0)
				sdo_r <= 1'b0;
			// RULE23 msb first
			else
				sdo_r <= word_r[idx[IDX_W-1:0]];
		end
	end

	// RULE1 shared ready and data line
	assign lnk.sdo    = sdo_r;
	assign lnk.sdo_oe = sdo_oe_r;
endmodule
`default_nettype wire

//--- src/asr_host.sv
// Purpose: Host reader: makes sclk, captures 32-bit words
// Assumes: Device turnaround fits within one sclk half period
// Notes:   Reads start only while the line shows ready
`timescale 1ns/1ps
`default_nettype none
module asr_host
	import asr_pkg::*;
#(
	parameter int SCLK_HALF = HOST_HALF
)
(
	input  wire logic              mclk,
	input  wire logic              sys_rst,
	input  wire logic              rd_req,
	output var  logic              rd_busy,
	output var  logic              dev_ready,
	output var  logic [WORD_W-1:0] rd_word,
	output var  logic              rd_valid,
	output var  logic              xfer_bad,
	asr_if.host                    lnk
);
	typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH} asr_hst_t;

	asr_hst_t          hst_r;
	logic [1:0]        line_s_r;
	logic [7:0]        half_r;
	logic [CNT_W-1:0]  bits_r;
	logic [WORD_W-1:0] shift_r;
	logic              sclk_r;

	initial
	begin
		if (SCLK_HALF < HOST_HALF_MIN || SCLK_HALF > 255)
			$error("asr_host: SCLK_HALF out of range");
	end

	always_ff @(posedge mclk)
	begin
		line_s_r <= {line_s_r[0], lnk.sdo_line};
	end

	////////////////////////////////////////////////////////////////////
	// Serial clock generator and shifter
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			hst_r    <= H_IDLE;
			sclk_r   <= 1'b1;
			half_r   <= '0;
			bits_r   <= '0;
			shift_r  <= '0;
			rd_word  <= '0;
			rd_valid <= 1'b0;
			xfer_bad <= 1'b0;
		end
		else
		begin
			rd_valid <= 1'b0;
			case (hst_r)
				H_IDLE:
				begin
					sclk_r <= 1'b1;
					// RULE16 start only when ready
					if (rd_req && !line_s_r[1])
					begin
						hst_r  <= H_LOW;
						sclk_r <= 1'b0;
						half_r <= 8'(SCLK_HALF - 1);
						bits_r <= '0;
					end
				end
				H_LOW:
				begin
					if (half_r == '0)
					begin
						// RULE3 sample on rising edge
						hst_r   <= H_HIGH;
						sclk_r  <= 1'b1;
						half_r  <= 8'(SCLK_HALF - 1);
						shift_r <= {shift_r[WORD_W-2:0], line_s_r[1]};
						bits_r  <= bits_r + 1'b1;
					end
					else
						half_r <= half_r - 1'b1;
				end
				H_HIGH:
				begin
					if (half_r != '0)
						half_r <= half_r - 1'b1;
					// RULE11 whole word then stop
					else if (bits_r == CNT_W'(WORD_W))
					begin
						hst_r    <= H_IDLE;
						rd_word  <= shift_r;
						rd_valid <= 1'b1;
						// RULE21 check pattern test
						xfer_bad <= shift_r[1:0] != CHECK_PAT;
					end
					else
					begin
						hst_r  <= H_LOW;
						sclk_r <= 1'b0;
						half_r <= 8'(SCLK_HALF - 1);
					end
				end
				default:
				begin
					hst_r  <= H_IDLE;
					sclk_r <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rd_busy   <= 1'b0;
			dev_ready <= 1'b0;
		end
		else
		begin
			rd_busy   <= (hst_r != H_IDLE) || (rd_req && !line_s_r[1]);
			dev_ready <= !line_s_r[1] && (hst_r == H_IDLE);
		end
	end

	// RULE1 host drives serial clock
	assign lnk.sclk = sclk_r;
endmodule
`default_nettype wire

//--- dv/asr_props.sv
// Purpose: Link checks for the serial result readout
// Assumes: Host sclk idles high between words
// Notes:   Helper logic counts sclk rises within one word
`timescale 1ns/1ps
`default_nettype none
module asr_props
#(
	parameter logic [1:0] PART_CODE = 2'h2
)
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic sdo_line
);
	logic       sclk_r;
	logic [5:0] rise_r;
	logic [5:0] idle_r;
	logic       real_r;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	// Rises seen in the current word
	always_ff @(posedge mclk)
	begin
		sclk_r <= sclk;
		if (sys_rst || idle_r == 6'h28)
			rise_r <= 6'h0;
		else if (sclk && !sclk_r)
			rise_r <= rise_r + 6'h1;
	end
	// Cycles with sclk high
	always_ff @(posedge mclk)
	begin
		if (sys_rst || !sclk)
			idle_r <= 6'h0;
		else if (idle_r != 6'h3f)
			idle_r <= idle_r + 6'h1;
	end
	// Word started while ready showed
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			real_r <= 1'b0;
		else if ($fell(sclk) && rise_r == 6'h0)
			real_r <= !sdo_line;
	end
	////////////////////////////////////////////////////////////////
	a_sclk_half_min: assert property (
		$changed(sclk) |=> $stable(sclk)[*7])
		else $error("sclk half period too short");
	a_word_len: assert property (
		$rose(sclk) |-> rise_r < 6'h20)
		else $error("more than 32 clocks in a word");
	a_bit_hold: assert property (
		$rose(sclk) && rise_r < 6'h1f |-> $stable(sdo_line)[*8])
		else $error("data bit moved while sclk high");
	a_done_high: assert property (
		$rose(sclk) && rise_r == 6'h1f |-> ##6 sdo_line[*8])
		else $error("line not high after full word");
	a_ready_zero: assert property (
		$rose(sclk) && rise_r == 6'h18 && real_r |-> !sdo_line)
		else $error("ready bit high in a real word");
	a_pad_zero: assert property (
		$rose(sclk) && rise_r == 6'h14 && real_r |-> !sdo_line)
		else $error("pad bit high in a real word");
	a_part_code: assert property (
		$rose(sclk) && rise_r == 6'h18 && !sdo_line
		|-> ##60 sdo_line == PART_CODE[1] ##20 sdo_line == PART_CODE[0])
		else $error("part code bits wrong");
	a_check_pat: assert property (
		$rose(sclk) && rise_r == 6'h18 && !sdo_line
		|-> ##120 !sdo_line ##20 sdo_line)
		else $error("check pattern not 0 then 1");
	c_word_done: cover property ($rose(sclk) && rise_r == 6'h1f);
	c_ready: cover property (sdo_oe && !sdo);
	c_off: cover property (!sdo_oe);
endmodule
`default_nettype wire

//--- dv/adc_serial_readout_port_tb.sv
// Purpose: Bench joining the converter port and the host reader
// Assumes: Shortened conversion and settle counts
// Notes:   Expected words queued by the driver, checked on rd_valid
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	error_cnt++; $display("BAD %0t got %h want %h", $time, (a), (b)); \
	end end
module adc_serial_readout_port_tb
	import asr_pkg::*;
;
	localparam int         PER   = 1000;
	localparam logic [1:0] PCODE = 2'h1; // Arbitrary part code
	logic              mclk;
	logic              sys_rst;
	logic              powerdown_reset_n;
	logic              rate_sel;
	logic              gain_sel;
	logic [RES_W-1:0]  conv_result;
	logic              conv_overrange;
	logic              rd_req;
	logic              rd_busy;
	logic              dev_ready;
	logic [WORD_W-1:0] rd_word;
	logic              rd_valid;
	logic              xfer_bad;
	logic [WORD_W-1:0] exp_w;
	logic [WORD_W-1:0] exp_q[$];
	int                error_cnt = 0;
	int                num_checks = 0;
	int                hi;
	asr_if lnk ();
	asr_dev #(.OSC_CYCLES(50), .PER10_CYCLES(PER), .PER16_CYCLES(PER),
		.SET10_CYCLES(3000), .SET16_CYCLES(2000), .PART_CODE(PCODE))
		u_asr_dev (.mclk(mclk), .sys_rst(sys_rst),
		.powerdown_reset_n(powerdown_reset_n), .rate_sel(rate_sel),
		.gain_sel(gain_sel), .conv_result(conv_result),
		.conv_overrange(conv_overrange), .lnk(lnk));
	asr_host u_asr_host (.mclk(mclk), .sys_rst(sys_rst), .rd_req(rd_req),
		.rd_busy(rd_busy), .dev_ready(dev_ready), .rd_word(rd_word),
		.rd_valid(rd_valid), .xfer_bad(xfer_bad), .lnk(lnk));
	asr_props #(.PART_CODE(PCODE)) u_asr_props (.mclk(mclk),
		.sys_rst(sys_rst), .sclk(lnk.sclk), .sdo(lnk.sdo),
		.sdo_oe(lnk.sdo_oe), .sdo_line(lnk.sdo_line));
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	function automatic logic [WORD_W-1:0] exp_word();
		return {conv_result, 4'h0, 1'h0, rate_sel, conv_overrange,
			PCODE, gain_sel, 2'h1};
	endfunction
	task automatic wait_rdy();
		int t;
		t = 0;
		while (dev_ready !== 1'b1 && t < 8000)
		begin
			cyc(1);
			t++;
		end
		`CHK(dev_ready, 1'b1)
	endtask
	task automatic do_read();
		int t;
		wait_rdy();
		exp_q.push_back(exp_word());
		rd_req = 1'b1;
		cyc(1);
		rd_req = 1'b0;
		t = 0;
		while (rd_valid !== 1'b1 && t < 800)
		begin
			cyc(1);
			t++;
		end
		`CHK(rd_valid, 1'b1)
		cyc(1);
	endtask
	////////////////////////////////////////////////////////////////
	// Word compare on each result
	always @(negedge mclk)
	begin
		if (rd_valid === 1'b1)
		begin
			exp_w = exp_q.pop_front();
			`CHK(rd_word, exp_w)
			`CHK(xfer_bad, 1'b0)
		end
	end
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		#(25 * 80000);
		error_cnt++;
		stop_test();
	end
	initial
	begin
		sys_rst = 1'b1;
		powerdown_reset_n = 1'b1;
		rate_sel = 1'b1;
		gain_sel = 1'b1;
		conv_result = '0;
		conv_overrange = 1'b0;
		rd_req = 1'b0;
		void'($urandom(32'hb9025c7f));
		cyc(20);
		sys_rst = 1'b0;
		// every rate and gain, edge codes
		for (int i = 0; i < 4; i++)
		begin
			wait_rdy();
			conv_result = i == 0 ? 20'h0 : i == 1 ? 20'h80000 :
				i == 2 ? 20'hfffff : RES_W'($urandom);
			conv_overrange = 1'($urandom);
			rate_sel = i[0];
			gain_sel = i[1];
			cyc(8);
			`CHK(lnk.sdo_line, 1'b1)
			cyc(1500);
			`CHK(dev_ready, 1'b0)
			do_read();
			cyc(10);
			`CHK(lnk.sdo_line, 1'b1)
			rd_req = 1'b1;
			cyc(2);
			rd_req = 1'b0;
			`CHK(rd_busy, 1'b0)
		end
		wait_rdy();
		conv_result = RES_W'($urandom);
		hi = 0;
		repeat (PER + 100)
		begin
			cyc(1);
			hi += int'(lnk.sdo_line);
		end
		`CHK(hi inside {[1:4]}, 1'b1)
		do_read();
		powerdown_reset_n = 1'b0;
		cyc(6);
		`CHK(lnk.sdo_oe, 1'b0)
		powerdown_reset_n = 1'b1;
		cyc(100);
		`CHK(lnk.sdo_line, 1'b1)
		`CHK(lnk.sdo_oe, 1'b1)
		`CHK(dev_ready, 1'b0)
		do_read();
		`CHK(exp_q.size(), 0)
		stop_test();
	end
endmodule
`default_nettype wire
